// File: core/fspc_pkg.sv
// Purpose: Constants shared by the flash self-program control block.
// Assumes: 10 MHz core clock, 8-bit register port.
// Notes:   Register offsets are local to the block's register port.
package fspc_pkg;
	localparam logic [1:0] FSPC_ADDR_CTRL    = 2'h0;
	localparam logic [1:0] FSPC_ADDR_LOCK    = 2'h1;
	localparam logic [1:0] FSPC_ADDR_STATUS  = 2'h2;
	localparam logic [7:0] FSPC_CTRL_RESET   = 8'h00;
	localparam logic [7:0] FSPC_LOCK_RESET   = 8'hFF;
	localparam logic [7:0] FSPC_LOCK_TOP     = 8'hC0;
	localparam int         FSPC_BIT_INT_EN   = 7;
	localparam int         FSPC_BIT_BUSY     = 6;
	localparam logic [4:0] FSPC_CMD_REEN     = 5'h11;
	localparam logic [4:0] FSPC_CMD_LOCK     = 5'h09;
	localparam logic [4:0] FSPC_CMD_WRITE    = 5'h05;
	localparam logic [4:0] FSPC_CMD_ERASE    = 5'h03;
	localparam logic [4:0] FSPC_CMD_FILL     = 5'h01;
	localparam logic [2:0] FSPC_ARM_CYCLES   = 3'h4;
	localparam logic [2:0] FSPC_LOAD_CYCLES  = 3'h3;
	localparam int         FSPC_CLK_HZ       = 10_000_000;
	localparam int         FSPC_PROG_US      = 3700;
	localparam int         FSPC_PROG_CYC     =
		(FSPC_PROG_US * (FSPC_CLK_HZ / 1_000_000));
	localparam logic [6:0] FSPC_FIRST_BLOCKING_PAGE = 7'h60;
	localparam int         FSPC_WORDS        = 32;
	typedef enum logic [3:0] {
		FSPC_IDLE  = 4'b0001,
		FSPC_ARMED = 4'b0010,
		FSPC_PROG  = 4'b0100,
		FSPC_LOCKW = 4'b1000
	} fspc_state_t;
endpackage

// File: core/fspc_ctrl.sv
// Purpose: Flash self-program sequencer with lock-bit enforcement.
// Assumes: Core issues store/load program strobes with pointer and data.
// Notes:   Flash cell array is outside; this block issues its commands.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.

// Overview of operation
// [R1] Ready interrupt while enabled, global set, idle
// [R2] Section program sets busy, blocks access
// [R3] Busy clears on re-enable or buffer load
// [R4] Read-enable plus store re-enables section
// [R5] No re-enable while erase/write in progress
// [R6] Re-enable aborts load, clears buffer
// [R7] Lock-set store programs lock bits from low
// [R8] Lock-set bit clears on completion or timeout
// [R9] Load within three cycles returns lock/fuse
// [R10] Page-write store writes buffer to page
// [R11] Page-write bit clears on completion or timeout
// [R12] Halt CPU during blocking-section programming
// [R13] Page-erase store erases page, auto-clears
// [R14] Store-only fills buffer word from data pair
// [R15] Store enable clears after store or timeout
// [R16] Only five listed patterns are accepted
// [R17] Bit five always reads zero
// [R18] Six lock bits, only chip erase sets
// [R19] General lock pair blocks external programming
// [R20] Application lock pair restricts store/load
// [R21] Locked-vector section disables interrupts elsewhere
// [R22] Boot lock pair restricts store/load
// [R23] Lock byte layout, top bits read one
// [R24] Page from Z12:Z6, word from Z5:Z1
module fspc_ctrl #(
	parameter int PROG_CYCLES = fspc_pkg::FSPC_PROG_CYC
) (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [1:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        global_int_en,
	input  wire logic        store_strobe,
	input  wire logic        load_strobe,
	input  wire logic [15:0] zptr,
	input  wire logic [7:0]  data_low_reg,
	input  wire logic [7:0]  data_high_reg,
	input  wire logic [7:0]  fuse_low,
	input  wire logic [7:0]  fuse_high,
	input  wire logic        exec_in_boot,
	input  wire logic        vectors_in_boot,
	input  wire logic [6:0]  boot_first_page,
	input  wire logic        chip_erase,
	output logic             prog_ready_irq,
	output logic             cpu_halt,
	output logic             rw_section_busy,
	output logic             int_block,
	output logic             store_denied,
	output logic             load_denied,
	output logic             ext_prog_lock,
	output logic             ext_verify_lock,
	output logic      [7:0]  load_data,
	output logic             load_data_valid,
	output logic             flash_erase_go,
	output logic             flash_write_go,
	output logic      [6:0]  flash_page
);
	import fspc_pkg::*;

	fspc_state_t       state_r;
	logic [4:0]        cmd_r;
	logic              int_en_r;
	logic [2:0]        arm_cnt_r;
	logic [31:0]       prog_cnt_r;
	logic [7:0]        lock_r;
	logic [7:0]        lock_src_r;
	logic [15:0]       buf_r [FSPC_WORDS];
	logic              blocking_r;
	logic [7:0]        lock_val;
	logic              cmd_ok;
	logic              tgt_boot;
	logic              store_ok;
	logic              done;
	logic [6:0]        page;
	logic [4:0]        word;
	logic              app_store_lock;
	logic              app_load_lock;
	logic              boot_store_lock;
	logic              boot_load_lock;

	// Pointer fields and target section of the current store.
	// Pointer bit 0 picks the byte on loads and is ignored by stores.
	// [R24] Pointer field split
	assign page     = zptr[12:6];
	assign word     = zptr[5:1];
	assign tgt_boot = (page >= boot_first_page);
	// [R16] Accepted patterns only
	assign cmd_ok   = (reg_wdata[4:0] == FSPC_CMD_REEN) ||
		(reg_wdata[4:0] == FSPC_CMD_LOCK) ||
		(reg_wdata[4:0] == FSPC_CMD_WRITE) ||
		(reg_wdata[4:0] == FSPC_CMD_ERASE) ||
		(reg_wdata[4:0] == FSPC_CMD_FILL);
	// Lock pairs: the low bit of a pair bars stores into its section,
	// the high bit bars loads from it; a programmed bit reads as zero.
	assign app_store_lock  = !lock_r[2];
	assign app_load_lock   = !lock_r[3];
	assign boot_store_lock = !lock_r[4];
	assign boot_load_lock  = !lock_r[5];
	// [R20] Application write lock
	// [R22] Boot write lock
	assign store_ok = tgt_boot ? !boot_store_lock : !app_store_lock;
	// Last count of the programming timer: the sequencer leaves on this
	// edge, so the timer runs exactly PROG_CYCLES cycles.
	assign done     = (prog_cnt_r == 32'h0000_0001);
	// [R23] Lock byte layout
	assign lock_val = lock_r | FSPC_LOCK_TOP;

	// Sequencer: arming window, programming timer and auto-clear.
	// The sequencer takes control writes only in idle, so no command can start
	// or re-enable the section while an erase or write is running.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_r    <= FSPC_IDLE;
			cmd_r      <= 5'h00;
			arm_cnt_r  <= 3'h0;
			prog_cnt_r <= 32'h0;
			blocking_r <= 1'b0;
			flash_page <= 7'h00;
			lock_src_r <= FSPC_LOCK_RESET;
		end else begin
			case (state_r)
				FSPC_IDLE: begin
					// [R5] Write ignored unless idle
					if (reg_wr && reg_addr == FSPC_ADDR_CTRL && cmd_ok) begin
						state_r   <= FSPC_ARMED;
						cmd_r     <= reg_wdata[4:0];
						arm_cnt_r <= FSPC_ARM_CYCLES;
					end
				end
				FSPC_ARMED: begin
					// [R15] Store or timeout clears
					if (store_strobe) begin
						if (cmd_r == FSPC_CMD_ERASE ||
							cmd_r == FSPC_CMD_WRITE) begin
							// [R13] Erase started
							// [R10] Write started
							if (store_ok) begin
								state_r    <= FSPC_PROG;
								prog_cnt_r <= PROG_CYCLES;
								blocking_r <=
									(page >= FSPC_FIRST_BLOCKING_PAGE);
								flash_page <= page;
							end else begin
								state_r <= FSPC_IDLE;
								cmd_r   <= 5'h00;
							end
						end else if (cmd_r == FSPC_CMD_LOCK) begin
							// [R7] Lock programming started
							// Data is latched now; the core may reuse
							// its data register while the timer runs.
							state_r    <= FSPC_LOCKW;
							prog_cnt_r <= PROG_CYCLES;
							lock_src_r <= data_low_reg;
						end else begin
							state_r <= FSPC_IDLE;
							cmd_r   <= 5'h00;
						end
					end else if (arm_cnt_r == 3'h1) begin
						// [R8] Timeout clears lock-set
						// [R11] Timeout clears page-write
						state_r <= FSPC_IDLE;
						cmd_r   <= 5'h00;
					end
					arm_cnt_r <= arm_cnt_r - 3'h1;
				end
				default: begin
					// [R11] Completion clears command
					prog_cnt_r <= prog_cnt_r - 32'h1;
					if (done) begin
						state_r    <= FSPC_IDLE;
						cmd_r      <= 5'h00;
						blocking_r <= 1'b0;
					end
				end
			endcase
		end
	end

	// One-cycle go pulses to the flash array.
	// Registered, so the array sees each pulse with the page that
	// was latched on the same edge.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			flash_erase_go <= 1'b0;
			flash_write_go <= 1'b0;
		end else begin
			flash_erase_go <= state_r == FSPC_ARMED && store_strobe &&
				store_ok && cmd_r == FSPC_CMD_ERASE;
			flash_write_go <= state_r == FSPC_ARMED && store_strobe &&
				store_ok && cmd_r == FSPC_CMD_WRITE;
		end
	end

	// Section busy flag; setting wins over clearing.
	// Busy rises the cycle after the go pulse; a page in the blocking section
	// halts the core instead and leaves the flag alone.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rw_section_busy <= 1'b0;
		end else if (flash_erase_go || flash_write_go) begin
			// [R2] Busy set on start
			if (!blocking_r)
				rw_section_busy <= 1'b1;
		end else if (state_r == FSPC_ARMED && store_strobe &&
			(cmd_r == FSPC_CMD_REEN || cmd_r == FSPC_CMD_FILL)) begin
			// [R3] Busy cleared
			// [R4] Section re-enabled
			rw_section_busy <= 1'b0;
		end
	end

	// Temporary page buffer.
	// Cleared words read as all ones, the erased state of a cell.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			for (int i = 0; i < FSPC_WORDS; i++)
				buf_r[i] <= 16'hFFFF;
		end else if (state_r == FSPC_ARMED && store_strobe) begin
			if (cmd_r == FSPC_CMD_REEN) begin
				// [R6] Abort load, clear buffer
				for (int i = 0; i < FSPC_WORDS; i++)
					buf_r[i] <= 16'hFFFF;
			end else if (cmd_r == FSPC_CMD_FILL) begin
				// [R14] Buffer word fill
				buf_r[word] <= {data_high_reg, data_low_reg};
			end
		end
	end

	// Lock bits: programming only clears, chip erase restores.
	// Chip erase outranks a lock write completing in the same cycle.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			lock_r <= FSPC_LOCK_RESET;
		end else if (chip_erase) begin
			// [R18] Chip erase restores
			lock_r <= FSPC_LOCK_RESET;
		end else if (state_r == FSPC_LOCKW && done) begin
			// [R7] Low data programs locks
			// Programming can only clear bits; the two top bits stay one.
			lock_r <= lock_r & (lock_src_r | FSPC_LOCK_TOP);
		end
	end

	// Control register fields held outside the sequencer.
	// The interrupt enable takes every control write, even one whose
	// low five bits are refused.
	always_ff @(posedge mclk) begin
		if (!nrst)
			int_en_r <= FSPC_CTRL_RESET[FSPC_BIT_INT_EN];
		else if (reg_wr && reg_addr == FSPC_ADDR_CTRL)
			int_en_r <= reg_wdata[FSPC_BIT_INT_EN];
	end

	// Register read port, data one cycle after the strobe.
	// Data falls back to zero when no read is pending, so a late
	// sample never shows a stale value.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == FSPC_ADDR_CTRL)
				// [R17] Bit five reads zero
				reg_rdata <= {int_en_r, rw_section_busy, 1'b0, cmd_r};
			else if (reg_addr == FSPC_ADDR_LOCK)
				reg_rdata <= lock_val;
			else if (reg_addr == FSPC_ADDR_STATUS)
				reg_rdata <= {4'h0, state_r};
			else
				reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Lock and fuse readback on load instructions.
	// The window is the first three armed cycles, counts 4 down to 2.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			load_data       <= 8'h00;
			load_data_valid <= 1'b0;
		end else begin
			load_data_valid <= 1'b0;
			// [R9] Lock or fuse read
			if (load_strobe && state_r == FSPC_ARMED &&
				cmd_r == FSPC_CMD_LOCK &&
				arm_cnt_r >= (FSPC_ARM_CYCLES - FSPC_LOAD_CYCLES + 3'h1)) begin
				load_data       <= zptr[0] ? fuse_high : lock_val;
				load_data_valid <= 1'b1;
				if (!zptr[0])
					load_data <= lock_val;
				else
					load_data <= fuse_low;
			end
		end
	end

	// Access protection and interrupt gating.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			prog_ready_irq  <= 1'b0;
			cpu_halt        <= 1'b0;
			int_block       <= 1'b0;
			store_denied    <= 1'b0;
			load_denied     <= 1'b0;
			ext_prog_lock   <= 1'b0;
			ext_verify_lock <= 1'b0;
		end else begin
			// [R1] Ready interrupt request
			prog_ready_irq <= int_en_r && global_int_en &&
				(state_r == FSPC_IDLE);
			// [R12] CPU halt
			cpu_halt <= (state_r == FSPC_PROG) && blocking_r;
			// Both external locks follow the general pair alone.
			// [R19] External lock modes
			ext_prog_lock   <= !lock_r[0];
			ext_verify_lock <= !lock_r[0] && !lock_r[1];
			store_denied    <= store_strobe && state_r == FSPC_ARMED &&
				(cmd_r == FSPC_CMD_ERASE || cmd_r == FSPC_CMD_WRITE) &&
				!store_ok;
			// [R20] Boot code reading application
			// [R22] Application code reading boot
			// [R2] Busy section blocked
			// A load is refused across sections where the target pair bars loads,
			// and from the application section while busy, even for code running there.
			load_denied <= load_strobe && (
				(exec_in_boot && !tgt_boot && app_load_lock) ||
				(!exec_in_boot && tgt_boot && boot_load_lock) ||
				(!tgt_boot && rw_section_busy));
			// [R21] Interrupts disabled across sections
			// Taken while the running section's pair bars loads and
			// the vectors lie in the other section.
			int_block <= (vectors_in_boot && !exec_in_boot &&
				app_load_lock) ||
				(!vectors_in_boot && exec_in_boot && boot_load_lock);
		end
	end
endmodule

// File: tb/fspc_chk_sva.sv
// Purpose: Port checks on the self-program sequencer.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Blocking pages start at the package constant.
module fspc_chk (
	input wire logic       mclk,
	input wire logic       nrst,
	input wire logic [1:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       global_int_en,
	input wire logic       store_strobe,
	input wire logic       load_strobe,
	input wire logic       prog_ready_irq,
	input wire logic       cpu_halt,
	input wire logic       rw_section_busy,
	input wire logic       ext_prog_lock,
	input wire logic       ext_verify_lock,
	input wire logic       load_data_valid,
	input wire logic       flash_erase_go,
	input wire logic       flash_write_go,
	input wire logic [6:0] flash_page
);
	timeunit 1ns;
	timeprecision 1ns;
	import fspc_pkg::*;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	chk_erase_cause:
	assert property (flash_erase_go |-> $past(store_strobe))
		else $error("erase launch without store");
	chk_write_cause:
	assert property (flash_write_go |-> $past(store_strobe))
		else $error("write launch without store");
	chk_busy_set:
	assert property ((flash_erase_go || flash_write_go) &&
		flash_page < FSPC_FIRST_BLOCKING_PAGE |=> rw_section_busy)
		else $error("busy not set");
	chk_halt_block:
	assert property ((flash_erase_go || flash_write_go) &&
		flash_page >= FSPC_FIRST_BLOCKING_PAGE |-> ##[0:1] cpu_halt)
		else $error("no halt on blocking page");
	chk_verify_lock:
	assert property (ext_verify_lock |-> ext_prog_lock)
		else $error("verify lock without program lock");
	chk_bit5_zero:
	assert property (reg_rd && reg_addr == FSPC_ADDR_CTRL |=> !reg_rdata[5])
		else $error("bit five read one");
	chk_irq_masked:
	assert property (!global_int_en [*2] |-> !prog_ready_irq)
		else $error("irq while masked");
	chk_load_cause:
	assert property (load_data_valid |-> $past(load_strobe))
		else $error("load data without load");
endmodule

// File: tb/fspc_cpu_model.sv
// Purpose: Core model issuing store and load program strobes.
// Assumes: One strobe a call, pointer and data valid with it.
// Notes:   Released lines show inverted values, not the last ones.
module fspc_cpu_model (
	input  wire logic        mclk,
	output logic             store_strobe,
	output logic             load_strobe,
	output logic      [15:0] zptr,
	output logic      [7:0]  data_low_reg,
	output logic      [7:0]  data_high_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle values at time zero.
	initial begin
		store_strobe = 1'b0;
		load_strobe = 1'b0;
		zptr = 16'h0000;
		data_low_reg = 8'h00;
		data_high_reg = 8'h00;
	end
	// One strobe cycle, then pointer and data are scrambled.
	task automatic issue(input logic st, input logic [15:0] z,
		input logic [7:0] lo);
		@(posedge mclk);
		zptr <= z;
		data_low_reg <= lo;
		data_high_reg <= ~lo;
		store_strobe <= st;
		load_strobe <= !st;
		@(posedge mclk);
		store_strobe <= 1'b0;
		load_strobe <= 1'b0;
		zptr <= ~z;
		data_low_reg <= ~lo;
		data_high_reg <= lo;
	endtask
endmodule

// File: tb/flash_self_program_control_tb.sv
// Purpose: Register-level tests of the self-program sequencer.
// Assumes: Programming time shortened to 20 cycles.
// Notes:   Tests share one flow; lock state carries over.
module flash_self_program_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fspc_pkg::*;
	logic        mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        global_int_en = 1'b0, chip_erase = 1'b0;
	logic [1:0]  reg_addr = 2'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, load_data, v;
	logic        store_strobe, load_strobe, prog_ready_irq, store_denied;
	logic        ext_prog_lock, ext_verify_lock, load_data_valid;
	logic [15:0] zptr;
	logic [7:0]  data_low_reg, data_high_reg;
	logic        exec_in_boot = 1'b0, vectors_in_boot = 1'b0;
	logic        cpu_halt, int_block, load_denied;
	logic        flash_erase_go, flash_write_go;
	logic [6:0]  flash_page;
	int          num_errors = 0, checks_done = 0;
	// Clock of 100 ns period.
	always #50 mclk = ~mclk;
	fspc_cpu_model cpu (.mclk, .store_strobe, .load_strobe, .zptr,
		.data_low_reg, .data_high_reg);
	fspc_ctrl #(.PROG_CYCLES(20)) dut (.mclk, .nrst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .global_int_en, .store_strobe,
		.load_strobe, .zptr, .data_low_reg, .data_high_reg,
		.fuse_low(8'hA5), .fuse_high(8'h5A), .exec_in_boot,
		.vectors_in_boot, .boot_first_page(7'h60), .chip_erase,
		.prog_ready_irq, .cpu_halt, .rw_section_busy(), .int_block,
		.store_denied, .load_denied, .ext_prog_lock, .ext_verify_lock,
		.load_data, .load_data_valid, .flash_erase_go, .flash_write_go,
		.flash_page);
	// Compare and count.
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Verdict and end of run.
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// One-cycle register write.
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Read; data stands in the cycle after the strobe.
	task automatic rd(input logic [1:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic rdc(input string n, input logic [1:0] a,
		input logic [7:0] e);
		rd(a);
		chk(n, v, e);
	endtask
	// Arm a command, then store within the window.
	task automatic op(input logic [7:0] c, input logic [15:0] z,
		input logic [7:0] lo);
		wr(FSPC_ADDR_CTRL, c);
		cpu.issue(1'b1, z, lo);
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 60; i++) begin
			rd(FSPC_ADDR_CTRL);
			if (v[0] === 1'b0) return;
		end
		num_errors++;
		$display("[ERR] idle wait expected 0 seen 1");
		close_out();
	endtask
	// Main sequence.
	initial begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		rdc("ctrl", FSPC_ADDR_CTRL, FSPC_CTRL_RESET);
		rdc("lock", FSPC_ADDR_LOCK, FSPC_LOCK_RESET);
		$display("test reset done");
		op(8'h03, 16'h0140, 8'h00);
		#1 chk("erase go", {7'h00, flash_erase_go}, 8'h01);
		chk("erase page", {1'b0, flash_page}, 8'h05);
		rdc("erase run", FSPC_ADDR_CTRL, 8'h43);
		wait_idle();
		rdc("busy holds", FSPC_ADDR_CTRL, 8'h40);
		wr(FSPC_ADDR_CTRL, 8'h07);
		rdc("bad pattern", FSPC_ADDR_CTRL, 8'h40);
		op(8'h11, 16'h0000, 8'h00);
		wait_idle();
		rdc("reenable", FSPC_ADDR_CTRL, 8'h00);
		op(8'h03, 16'h0140, 8'h00);
		wait_idle();
		op(8'h01, 16'h0002, 8'h5A);
		wait_idle();
		rdc("fill", FSPC_ADDR_CTRL, 8'h00);
		$display("test erase done");
		op(8'h09, 16'h0000, 8'hF8);
		wait_idle();
		rdc("lock set", FSPC_ADDR_LOCK, 8'hF8);
		chk("verify lock", {7'h00, ext_verify_lock}, 8'h01);
		chk("prog lock", {7'h00, ext_prog_lock}, 8'h01);
		wr(FSPC_ADDR_CTRL, 8'h09);
		cpu.issue(1'b0, 16'h0000, 8'h00);
		#1 chk("lock load", load_data, 8'hF8);
		repeat (5) @(posedge mclk);
		rdc("lock timeout", FSPC_ADDR_CTRL, 8'h00);
		wr(FSPC_ADDR_CTRL, 8'h09);
		cpu.issue(1'b0, 16'h0001, 8'h00);
		#1 chk("fuse load", load_data, 8'hA5);
		repeat (5) @(posedge mclk);
		op(8'h05, 16'h0140, 8'h00);
		#1 chk("app denied", {7'h00, store_denied}, 8'h01);
		wait_idle();
		op(8'h05, 16'h1800, 8'h00);
		#1 chk("write go", {7'h00, flash_write_go}, 8'h01);
		@(posedge mclk);
		#1 chk("halt", {7'h00, cpu_halt}, 8'h01);
		chk("write page", {1'b0, flash_page}, 8'h60);
		wait_idle();
		chk("halt over", {7'h00, cpu_halt}, 8'h00);
		$display("test lock done");
		wr(FSPC_ADDR_CTRL, 8'h03);
		repeat (6) @(posedge mclk);
		rdc("arm timeout", FSPC_ADDR_CTRL, 8'h00);
		@(posedge mclk);
		global_int_en <= 1'b1;
		wr(FSPC_ADDR_CTRL, 8'h80);
		repeat (2) @(posedge mclk);
		#1 chk("ready irq", {7'h00, prog_ready_irq}, 8'h01);
		op(8'h89, 16'h0000, 8'hD8);
		#1 chk("irq armed", {7'h00, prog_ready_irq}, 8'h00);
		wait_idle();
		rdc("boot lock", FSPC_ADDR_LOCK, 8'hD8);
		cpu.issue(1'b0, 16'h1800, 8'h00);
		#1 chk("boot load", {7'h00, load_denied}, 8'h01);
		@(posedge mclk);
		exec_in_boot <= 1'b1;
		@(posedge mclk);
		#1 chk("int block", {7'h00, int_block}, 8'h01);
		@(posedge mclk);
		vectors_in_boot <= 1'b1;
		@(posedge mclk);
		#1 chk("int free", {7'h00, int_block}, 8'h00);
		cpu.issue(1'b0, 16'h0140, 8'h00);
		#1 chk("app load", {7'h00, load_denied}, 8'h00);
		@(posedge mclk);
		chip_erase <= 1'b1;
		@(posedge mclk);
		chip_erase <= 1'b0;
		rdc("chip erase", FSPC_ADDR_LOCK, 8'hFF);
		$display("test misc done");
		close_out();
	end
endmodule
bind fspc_ctrl fspc_chk u_chk (.mclk, .nrst, .reg_addr, .reg_rd,
	.reg_rdata, .global_int_en, .store_strobe, .load_strobe,
	.prog_ready_irq, .cpu_halt, .rw_section_busy, .ext_prog_lock,
	.ext_verify_lock, .load_data_valid, .flash_erase_go, .flash_write_go,
	.flash_page);
